//--- verilog/tcd_pkg.sv
// constants shared by the tape control command decoder
package tcd_pkg;
  // in-out device codes, low six bits of the instruction address
  localparam logic [5:0] TCD_DEV_STATE = 6'h3A;
  localparam logic [5:0] TCD_DEV_UNIT = 6'h38;
  localparam logic [5:0] TCD_DEV_FUNC = 6'h39;
  localparam logic [5:0] TCD_DEV_STOP = 6'h3B;
  // pulse-select field for the stop command
  localparam logic [5:0] TCD_SEL_STOP = 6'h00;
  // clear-proceed bit inside the microprogrammed select field
  localparam int TCD_SEL_CPM_BIT = 2;
  // unit/density/rewind register fields
  localparam int TCD_UR_REWIND = 5;
  localparam int TCD_UR_DEN_HI = 4;
  localparam int TCD_UR_DEN_LO = 3;
  localparam int TCD_UR_UNIT_HI = 2;
  // function register fields
  localparam int TCD_FN_LOW_SLICE = 5;
  localparam int TCD_FN_EOF = 4;
  localparam int TCD_FN_FWD = 3;
  localparam int TCD_FN_READ = 2;
  localparam int TCD_FN_EVEN = 1;
  localparam int TCD_FN_CHAIN = 0;
  // unit field value that stands for the eighth transport
  localparam logic [2:0] TCD_UNIT_WRAP = 3'h0;
  localparam logic [3:0] TCD_UNIT_EIGHT = 4'h8;
  // values after reset
  localparam logic [5:0] TCD_REG_RST = 6'h00;
  localparam logic [2:0] TCD_SYNC_RST = 3'h0;
  // synchroniser depth for transport status pins
  localparam int TCD_SYNC_STAGES = 2;
endpackage

//--- verilog/tcd_legal_check.sv
// transport status synchroniser and function legality check
`timescale 1ns/10ps
module tcd_legal_check (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ready_write_pin,
  input wire logic ready_read_pin,
  input wire logic load_point_pin,
  input wire logic [5:0] func_bits,
  input wire logic rewind_req,
  output logic illegal,
  output logic at_load_point
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
  } tcd_sync_t;

  tcd_sync_t state_reg;
  tcd_sync_t state_next;
  logic rdy_wr;
  logic rdy_rd;

  // first stage feeds only the second stage
  always_comb begin
    state_next = state_reg;
    state_next.s1 = {load_point_pin, ready_read_pin, ready_write_pin};
    state_next.s2 = state_reg.s1;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '{s1: tcd_pkg::TCD_SYNC_RST, s2: tcd_pkg::TCD_SYNC_RST};
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdy_wr = state_reg.s2[0];
  assign rdy_rd = state_reg.s2[1];
  assign at_load_point = state_reg.s2[2];

  // write unready, rewind or reverse at load point, or read unready
  assign illegal = (!func_bits[tcd_pkg::TCD_FN_READ] && !rdy_wr)
    || ((rewind_req || !func_bits[tcd_pkg::TCD_FN_FWD]) && at_load_point)
    || (func_bits[tcd_pkg::TCD_FN_READ] && !rdy_rd);
endmodule

//--- verilog/tcd_decode.sv
// tape control in-out command decoder
`timescale 1ns/10ps
module tcd_decode (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic iot_pulse,
  input wire logic [0:17] memory_buffer_bus,
  input wire logic function_done,
  input wire logic ready_write_pin,
  input wire logic ready_read_pin,
  input wire logic load_point_pin,
  output logic restart_pulse,
  output logic busy,
  output logic proceed,
  output logic illegal_last,
  output logic clear_indicate_pulse,
  output logic stop_transport_pulse,
  output logic next_block_pulse,
  output logic dismiss_pulse,
  output logic [5:0] unit_density_rewind,
  output logic [5:0] tape_function,
  output logic rewind_req,
  output logic [1:0] density_sel,
  output logic [3:0] unit_number,
  output logic low_slice,
  output logic write_eof,
  output logic dir_forward,
  output logic read_mode,
  output logic even_parity,
  output logic chain_mode
);
  typedef struct packed {
    logic [5:0] unit;
    logic [5:0] func;
    logic busy;
    logic proceed;
    logic illegal;
    logic restart;
    logic clr_ind;
    logic stop;
    logic next_blk;
    logic dismiss;
  } tcd_state_t;

  tcd_state_t state_reg;
  tcd_state_t state_next;
  logic [5:0] sel_field;
  logic [5:0] dev_field;
  logic is_cpm;
  logic is_unit;
  logic is_func;
  logic is_stop;
  logic new_illegal;
  logic at_lp;

  assign sel_field = memory_buffer_bus[6:11];
  assign dev_field = memory_buffer_bus[12:17];
  // cpm may ride in the same microprogrammed word as the state read
  assign is_cpm = iot_pulse && dev_field == tcd_pkg::TCD_DEV_STATE
    && sel_field[tcd_pkg::TCD_SEL_CPM_BIT];
  assign is_unit = iot_pulse && dev_field == tcd_pkg::TCD_DEV_UNIT;
  assign is_func = iot_pulse && dev_field == tcd_pkg::TCD_DEV_FUNC;
  assign is_stop = iot_pulse && dev_field == tcd_pkg::TCD_DEV_STOP
    && sel_field == tcd_pkg::TCD_SEL_STOP;

  // legality judged on the incoming word, rewind from the held unit register
  tcd_legal_check u_check (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ready_write_pin(ready_write_pin),
    .ready_read_pin(ready_read_pin),
    .load_point_pin(load_point_pin),
    .func_bits(sel_field),
    .rewind_req(state_reg.unit[tcd_pkg::TCD_UR_REWIND]),
    .illegal(new_illegal),
    .at_load_point(at_lp)
  );

  always_comb begin
    state_next = state_reg;
    state_next.restart = 1'b0;
    state_next.clr_ind = 1'b0;
    state_next.stop = 1'b0;
    state_next.next_blk = 1'b0;
    state_next.dismiss = 1'b0;
    // end of a function: chain on, or let go of the control
    if (function_done && state_reg.busy) begin
      if (state_reg.proceed) begin
        state_next.next_blk = 1'b1;
      end else begin
        state_next.busy = 1'b0;
        state_next.dismiss = 1'b1;
      end
    end
    if (is_cpm) begin
      state_next.proceed = 1'b0;
    end
    if (is_unit) begin
      state_next.unit = sel_field;
    end
    if (is_func) begin
      state_next.func = sel_field;
      state_next.clr_ind = 1'b1;
      state_next.restart = 1'b1;
      state_next.illegal = new_illegal;
      state_next.busy = !new_illegal;
      state_next.proceed = !new_illegal && sel_field[tcd_pkg::TCD_FN_CHAIN];
    end
    // maintenance stop also frees the control, motion cannot finish
    if (is_stop) begin
      state_next.stop = 1'b1;
      state_next.busy = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '{unit: tcd_pkg::TCD_REG_RST, func: tcd_pkg::TCD_REG_RST,
        default: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign restart_pulse = state_reg.restart;
  assign busy = state_reg.busy;
  assign proceed = state_reg.proceed;
  assign illegal_last = state_reg.illegal;
  assign clear_indicate_pulse = state_reg.clr_ind;
  assign stop_transport_pulse = state_reg.stop;
  assign next_block_pulse = state_reg.next_blk;
  assign dismiss_pulse = state_reg.dismiss;
  assign unit_density_rewind = state_reg.unit;
  assign tape_function = state_reg.func;

  // unit field decode
  assign rewind_req = state_reg.unit[tcd_pkg::TCD_UR_REWIND];
  assign density_sel = state_reg.unit[tcd_pkg::TCD_UR_DEN_HI:tcd_pkg::TCD_UR_DEN_LO];
  assign unit_number = (state_reg.unit[tcd_pkg::TCD_UR_UNIT_HI:0] == tcd_pkg::TCD_UNIT_WRAP)
    ? tcd_pkg::TCD_UNIT_EIGHT
    : {1'b0, state_reg.unit[tcd_pkg::TCD_UR_UNIT_HI:0]};

  // function field decode
  assign low_slice = state_reg.func[tcd_pkg::TCD_FN_LOW_SLICE];
  assign write_eof = state_reg.func[tcd_pkg::TCD_FN_EOF];
  assign dir_forward = state_reg.func[tcd_pkg::TCD_FN_FWD];
  assign read_mode = state_reg.func[tcd_pkg::TCD_FN_READ];
  assign even_parity = state_reg.func[tcd_pkg::TCD_FN_EVEN];
  assign chain_mode = state_reg.func[tcd_pkg::TCD_FN_CHAIN];

  // checks
  sequence s_func_load;
    is_func && !is_stop;
  endsequence

  sequence s_quiet_end;
    function_done && busy && !proceed && !iot_pulse;
  endsequence

  chk_cpm_clears : assert property (@(posedge clk_sys) disable iff (!rst_b)
    is_cpm && !is_func |=> !proceed) else $error("proceed not cleared");

  chk_quiet_release : assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_quiet_end |=> !busy && dismiss_pulse ##1 !dismiss_pulse)
    else $error("control not released");

  chk_unit_capture : assert property (@(posedge clk_sys) disable iff (!rst_b)
    is_unit |=> unit_density_rewind == $past(memory_buffer_bus[6:11]))
    else $error("unit register not loaded");

  chk_unit_number : assert property (@(posedge clk_sys) disable iff (!rst_b)
    unit_number >= 4'h1 && unit_number <= 4'h8
    && (unit_number[2:0] == unit_density_rewind[2:0]))
    else $error("unit decode wrong");

  chk_func_capture : assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_func_load |=> tape_function == $past(memory_buffer_bus[6:11]) && clear_indicate_pulse)
    else $error("function register not loaded");

  chk_illegal_busy : assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_func_load and new_illegal |=> !busy && restart_pulse && illegal_last)
    else $error("illegal function left busy");

  chk_legal_busy : assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_func_load and !new_illegal |=> busy && restart_pulse && !illegal_last)
    else $error("legal function not busy");

  chk_restart_single : assert property (@(posedge clk_sys) disable iff (!rst_b)
    restart_pulse |=> !restart_pulse || $past(is_func))
    else $error("restart pulse too long");

  chk_chain_next : assert property (@(posedge clk_sys) disable iff (!rst_b)
    function_done && busy && proceed && !iot_pulse |=> busy && next_block_pulse)
    else $error("chain did not continue");

  chk_stop_motion : assert property (@(posedge clk_sys) disable iff (!rst_b)
    is_stop |=> stop_transport_pulse && !busy)
    else $error("stop not issued");

  chk_illegal_cause : assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_func_load and at_lp && !memory_buffer_bus[8] |=> !busy)
    else $error("reverse at load point accepted");
endmodule

//--- testbench/tcd_host_model.sv
// host processor model issuing in-out transfer words
`timescale 1ns/10ps
module tcd_host_model (
  input wire logic clk_sys,
  output logic iot_pulse,
  output logic [0:17] memory_buffer_bus
);
  initial begin
    iot_pulse = 1'b0;
    memory_buffer_bus = 18'h00000;
  end
  // one word per instruction, strobe held for exactly one cycle
  task automatic issue(input logic [0:17] word);
    @(negedge clk_sys);
    iot_pulse = 1'b1;
    memory_buffer_bus = word;
    @(negedge clk_sys);
    iot_pulse = 1'b0;
    // word is stale once the strobe drops, so show its inverse
    memory_buffer_bus = ~word;
  endtask
endmodule

//--- testbench/testbench.sv
// self-checking bench for the tape control command decoder
`timescale 1ns/10ps
module testbench;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic function_done = 1'b0;
  logic ready_write_pin = 1'b0;
  logic ready_read_pin = 1'b0;
  logic load_point_pin = 1'b0;
  logic iot_pulse;
  logic [0:17] memory_buffer_bus;
  logic restart_pulse, busy, proceed, illegal_last, clear_indicate_pulse;
  logic stop_transport_pulse, next_block_pulse, dismiss_pulse, rewind_req;
  logic low_slice, write_eof, dir_forward, read_mode, even_parity, chain_mode;
  logic [5:0] unit_density_rewind;
  logic [5:0] tape_function;
  logic [1:0] density_sel;
  logic [3:0] unit_number;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int m_unit;
  int m_func;
  bit m_busy;
  bit m_proceed;
  bit m_ill;

  tcd_host_model u_host (.clk_sys, .iot_pulse, .memory_buffer_bus);
  tcd_decode u_dut (.clk_sys, .rst_b, .iot_pulse, .memory_buffer_bus, .function_done,
    .ready_write_pin, .ready_read_pin, .load_point_pin, .restart_pulse, .busy, .proceed,
    .illegal_last, .clear_indicate_pulse, .stop_transport_pulse, .next_block_pulse,
    .dismiss_pulse, .unit_density_rewind, .tape_function, .rewind_req, .density_sel,
    .unit_number, .low_slice, .write_eof, .dir_forward, .read_mode, .even_parity,
    .chain_mode);

  always #20 clk_sys = ~clk_sys;

  // about 40 loops of under 20 cycles each, so this ceiling is generous
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (fails == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic do_reset;
    @(negedge clk_sys);
    rst_b = 1'b0;
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    m_unit = 0;
    m_func = 0;
    m_busy = 0;
    m_proceed = 0;
    chk({busy, proceed, illegal_last, restart_pulse, unit_number}, 8'h08);
    chk({2'b00, unit_density_rewind}, 8'h00);
    chk({2'b00, tape_function}, 8'h00);
  endtask

  task automatic do_unit(input logic [5:0] xx);
    int un;
    u_host.issue({6'h3A, xx, tcd_pkg::TCD_DEV_UNIT});
    m_unit = xx;
    un = (xx % 8 == 0) ? 8 : xx % 8;
    chk({2'b00, unit_density_rewind}, 8'(m_unit));
    chk({1'b0, rewind_req, density_sel, unit_number},
      8'(xx / 32 * 64 + xx / 8 % 4 * 16 + un));
  endtask

  task automatic do_func(input logic [5:0] xx);
    m_ill = (!xx[2] && !ready_write_pin) || ((m_unit[5] || !xx[3]) && load_point_pin)
      || (xx[2] && !ready_read_pin);
    u_host.issue({6'h3A, xx, tcd_pkg::TCD_DEV_FUNC});
    m_func = xx;
    m_busy = !m_ill;
    m_proceed = !m_ill && xx[0];
    chk({2'b00, tape_function}, 8'(m_func));
    chk({2'b00, low_slice, write_eof, dir_forward, read_mode, even_parity, chain_mode},
      8'(xx));
    chk({4'h0, restart_pulse, clear_indicate_pulse, busy, illegal_last},
      {6'h03, m_busy, m_ill});
    chk({proceed, 1'b0, unit_density_rewind}, {m_proceed, 1'b0, 6'(m_unit)});
  endtask

  task automatic do_done;
    bit nb;
    bit dm;
    nb = m_busy && m_proceed;
    dm = m_busy && !m_proceed;
    m_busy = nb;
    @(negedge clk_sys);
    function_done = 1'b1;
    @(negedge clk_sys);
    function_done = 1'b0;
    chk({4'h0, next_block_pulse, dismiss_pulse, busy, restart_pulse},
      {4'h0, nb, dm, m_busy, 1'b0});
  endtask

  task automatic do_stop(input logic [5:0] xx);
    u_host.issue({6'h3A, xx, tcd_pkg::TCD_DEV_STOP});
    if (xx == 6'h00) begin
      m_busy = 0;
    end
    chk({6'h00, stop_transport_pulse, busy}, {6'h00, xx == 6'h00, m_busy});
  endtask

  initial begin
    int pick;
    void'($urandom(82));
    do_reset();
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_sys);
      {ready_write_pin, ready_read_pin, load_point_pin} = 3'($urandom);
      // pins pass a two-stage synchroniser before legality sees them
      repeat (4) @(negedge clk_sys);
      do_unit(6'($urandom));
      do_func(6'($urandom));
      pick = $urandom % 3;
      if (pick == 0) begin
        u_host.issue({6'h3A, 6'h04, tcd_pkg::TCD_DEV_STATE});
        m_proceed = 0;
        chk({6'h00, proceed, busy}, {6'h00, m_proceed, m_busy});
      end else if (pick == 1) begin
        do_stop(6'($urandom % 2));
      end
      do_done();
      do_done();
    end
    do_reset();
    wrap_up();
  end
endmodule
